// >>> host_model.sv
// host_model: host memory, record source and completion sink
// assumes: one clock; slow_i inserts stalls on every handshake
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic [63:0] key_i,
	input wire logic rd_req_i,
	output logic rd_ack_o,
	output logic [63:0] rd_data_o,
	input wire logic wr_valid_i,
	input wire logic [63:0] wr_addr_i,
	input wire logic [31:0] wr_data_i,
	output logic wr_ready_o,
	input wire logic [18:0] rec_index_i,
	output logic [31:0] rec_data_o,
	output logic cpl_ready_o
);
	logic [1:0] dly;
	logic [31:0] mem [logic [63:0]];
	int wr_cnt;
	assign wr_ready_o = !slow_i || dly[0];
	assign cpl_ready_o = !slow_i || dly == 2'h3;
	assign rec_data_o = {16'hC0DE, rec_index_i[15:0]};
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dly <= 2'h0;
			rd_ack_o <= 1'b0;
			rd_data_o <= 64'h0;
		end else begin
			dly <= dly + 2'h1;
			rd_ack_o <= rd_req_i && !rd_ack_o && (!slow_i || dly == 2'h1);
			rd_data_o <= (rd_req_i && !rd_ack_o) ? key_i : ~rd_data_o;
		end
	end
	always @(posedge clk_i) begin
		if (wr_valid_i && wr_ready_o) begin
			mem[wr_addr_i] = wr_data_i;
			wr_cnt++;
		end
	end
endmodule
`default_nettype wire

// >>> reservation_release_report.sv
// reservation_release_report: interprets the reservation release and
// reservation report commands, fetches the key, writes the status
// structure and posts the completion entry.
// assumes: all inputs come from logic on clk_i; memory and completion
// ports answer with handshakes; reservation state other than the generation counter lives outside.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - release action requires supplied reservation kind to equal the held kind.
// - key check bypass set skips key comparison; command succeeds on any key.
// - action 000b is release, 001b is clear, other codes are reserved.
// - every finished command posts a completion entry with its status.
// - report writes the reservation status structure into host memory.
// - structure size grows by one record per registered controller.
// - report uses dword 10 and pointer only; other fields are ignored.
// - pointer select zero: first PRP entry gives the destination buffer.
// - second PRP entry unused, second buffer, or list pointer by length.
// - pointer select one: whole pointer is first scatter-gather segment.
// - successful clear increments the wrapping 32-bit generation counter.
// - dword count is zero based; transfer is truncated to structure size.
module reservation_release_report #(
	parameter int REGW = 16,
	parameter int PAGE_BYTES = 4096,
	parameter logic [7:0] OPC_RELEASE = 8'h01,
	parameter logic [7:0] OPC_REPORT = 8'h02
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic [31:0] cmd_cdw0_i,
	input wire logic [31:0] cmd_cdw10_i,
	input wire logic [127:0] cmd_dptr_i,
	input wire logic [15:0] cmd_sqid_i,
	input wire logic [7:0] held_kind_i,
	input wire logic [63:0] holder_key_i,
	input wire logic [REGW-1:0] reg_count_i,
	input wire logic ptpl_i,
	input wire logic gen_bump_i,
	output logic rd_req_o,
	output logic [63:0] rd_addr_o,
	input wire logic rd_ack_i,
	input wire logic [63:0] rd_data_i,
	output logic wr_valid_o,
	output logic [63:0] wr_addr_o,
	output logic [31:0] wr_data_o,
	input wire logic wr_ready_i,
	output logic [REGW+2:0] rec_index_o,
	input wire logic [31:0] rec_data_i,
	output logic cpl_valid_o,
	output logic [15:0] cpl_sqid_o,
	output logic [15:0] cpl_cid_o,
	output logic [7:0] cpl_status_o,
	input wire logic cpl_ready_i,
	output logic release_o,
	output logic clear_o,
	output logic [31:0] generation_counter_o
);
	localparam int XW = REGW + 3;
	localparam int PB = $clog2(PAGE_BYTES);

	// ==========================================================
	// parameter checks
	generate
		if (PAGE_BYTES < 8 || (1 << PB) != PAGE_BYTES || REGW < 1 || REGW > 28) begin : g_bad
			$error("unsupported page size or count width");
		end
	endgenerate

	typedef enum {S_IDLE, S_KEY_RD, S_CHECK, S_SEL, S_LOAD, S_PUT, S_LIST_RD,
		S_CPL} state_e;

	// ==========================================================
	// header dword of the status structure
	function automatic logic [31:0] hdr_dword(input logic [XW-1:0] idx,
		input logic [31:0] gen, input logic [7:0] kind,
		input logic [REGW-1:0] regs, input logic ptpl);
		logic [31:0] v;
		v = 32'h0;
		if (idx == XW'(resv_cmd_pkg::HDR_GEN)) begin
			v = gen;
		end else if (idx == XW'(resv_cmd_pkg::HDR_KIND)) begin
			v = {8'h00, 16'(regs), kind};
		end else if (idx == XW'(resv_cmd_pkg::HDR_PTPL)) begin
			v[resv_cmd_pkg::PTPL_BIT] = ptpl;
		end
		return v;
	endfunction

	state_e state, next_state;
	logic next_cmd_ready, next_rd_req, next_wr_valid, next_cpl_valid;
	logic next_release, next_clear;
	logic [63:0] next_rd_addr, next_wr_addr, addr, next_addr;
	logic [63:0] ptr2, next_ptr2, list_ptr, next_list_ptr;
	logic [31:0] next_wr_data, next_gen;
	logic [XW-1:0] next_rec_index, idx, next_idx, total, next_total;
	logic [15:0] next_cpl_sqid, next_cpl_cid;
	logic [7:0] next_cpl_status, kind_req, next_kind_req;
	logic [2:0] act, next_act;
	logic bypass, next_bypass, key_match, next_key_match;
	logic use_sgl, next_use_sgl, need_list, next_need_list;
	logic crossed, next_crossed;
	logic [33:0] want, size, len;
	logic [63:0] step_addr;
	logic [XW-1:0] step_idx;
	logic check_ok;

	always_comb begin
		next_state = state;
		next_cmd_ready = cmd_ready_o;
		next_rd_req = rd_req_o;
		next_rd_addr = rd_addr_o;
		next_wr_valid = wr_valid_o;
		next_wr_addr = wr_addr_o;
		next_wr_data = wr_data_o;
		next_rec_index = rec_index_o;
		next_cpl_valid = cpl_valid_o;
		next_cpl_sqid = cpl_sqid_o;
		next_cpl_cid = cpl_cid_o;
		next_cpl_status = cpl_status_o;
		next_release = 1'b0;
		next_clear = 1'b0;
		next_gen = generation_counter_o;
		next_addr = addr;
		next_ptr2 = ptr2;
		next_list_ptr = list_ptr;
		next_idx = idx;
		next_total = total;
		next_kind_req = kind_req;
		next_act = act;
		next_bypass = bypass;
		next_key_match = key_match;
		next_use_sgl = use_sgl;
		next_need_list = need_list;
		next_crossed = crossed;
		// zero-based count, truncated to structure size
		want = {2'b00, cmd_cdw10_i} + 34'h1;
		size = 34'(resv_cmd_pkg::HDR_DW) +
			34'(resv_cmd_pkg::REC_DW) * 34'(reg_count_i);
		len = (want < size) ? want : size;
		step_addr = addr + resv_cmd_pkg::DW_BYTES;
		step_idx = idx + XW'(1);
		// kind must match held kind for release
		check_ok = (bypass || key_match) &&
			(act == resv_cmd_pkg::ACT_CLEAR || kind_req == held_kind_i);
		if (gen_bump_i) begin
			next_gen = generation_counter_o + 32'h1;
		end
		case (state)
			S_IDLE: begin
				if (cmd_valid_i && cmd_ready_o) begin
					next_cmd_ready = 1'b0;
					next_cpl_sqid = cmd_sqid_i;
					next_cpl_cid = cmd_cdw0_i[resv_cmd_pkg::CDW0_CID_HI:
						resv_cmd_pkg::CDW0_CID_LO];
					next_cpl_status = resv_cmd_pkg::ST_SUCCESS;
					next_use_sgl = cmd_cdw0_i[resv_cmd_pkg::CDW0_DPTR_SEL_BIT];
					// first entry or segment address is the buffer
					// segment address sits in the low pointer half
					next_addr = cmd_dptr_i[resv_cmd_pkg::PTR1_HI:
						resv_cmd_pkg::PTR1_LO];
					next_ptr2 = cmd_dptr_i[resv_cmd_pkg::PTR2_HI:
						resv_cmd_pkg::PTR2_LO];
					next_list_ptr = next_ptr2;
					next_crossed = 1'b0;
					next_idx = '0;
					next_kind_req = cmd_cdw10_i[resv_cmd_pkg::KIND_HI:
						resv_cmd_pkg::KIND_LO];
					next_act = cmd_cdw10_i[resv_cmd_pkg::ACT_HI:
						resv_cmd_pkg::ACT_LO];
					next_bypass = cmd_cdw10_i[resv_cmd_pkg::BYPASS_BIT];
					next_key_match = 1'b0;
					// only dword 10 and the pointer are used
					if (cmd_cdw0_i[resv_cmd_pkg::CDW0_OPC_HI:
						resv_cmd_pkg::CDW0_OPC_LO] == OPC_REPORT) begin
						next_total = XW'(len);
						next_need_list = !next_use_sgl &&
							(34'(next_addr[PB-1:0]) + (len << 2) >
							34'(2 * PAGE_BYTES));
						if (next_use_sgl && (len << 2) > 34'(cmd_dptr_i[
							resv_cmd_pkg::SGL_LEN_HI:
							resv_cmd_pkg::SGL_LEN_LO])) begin
							next_cpl_status = resv_cmd_pkg::ST_SGL_LENGTH;
							next_state = S_CPL;
						end else begin
							next_state = S_SEL;
						end
					end else if (cmd_cdw0_i[resv_cmd_pkg::CDW0_OPC_HI:
						resv_cmd_pkg::CDW0_OPC_LO] == OPC_RELEASE) begin
						if (next_act != resv_cmd_pkg::ACT_RELEASE &&
							next_act != resv_cmd_pkg::ACT_CLEAR) begin
							next_cpl_status = resv_cmd_pkg::ST_BAD_FIELD;
							next_state = S_CPL;
						end else if (next_bypass) begin
							next_state = S_CHECK;
						end else begin
							// fetch present key from release data
							next_rd_req = 1'b1;
							next_rd_addr = next_addr;
							next_state = S_KEY_RD;
						end
					end else begin
						next_cpl_status = resv_cmd_pkg::ST_BAD_OPCODE;
						next_state = S_CPL;
					end
				end
			end
			S_KEY_RD: begin
				if (rd_ack_i) begin
					next_rd_req = 1'b0;
					next_key_match = (rd_data_i == holder_key_i);
					next_state = S_CHECK;
				end
			end
			S_CHECK: begin
				if (check_ok) begin
					next_release = (act == resv_cmd_pkg::ACT_RELEASE);
					next_clear = (act == resv_cmd_pkg::ACT_CLEAR);
					if (act == resv_cmd_pkg::ACT_CLEAR) begin
						next_gen = generation_counter_o +
							(gen_bump_i ? 32'h2 : 32'h1);
					end
				end else begin
					next_cpl_status = resv_cmd_pkg::ST_CONFLICT;
				end
				next_state = S_CPL;
			end
			S_SEL: begin
				next_rec_index = idx - XW'(resv_cmd_pkg::HDR_DW);
				next_state = S_LOAD;
			end
			S_LOAD: begin
				// header or record dword into host memory
				if (idx < XW'(resv_cmd_pkg::HDR_DW)) begin
					next_wr_data = hdr_dword(idx, generation_counter_o,
						held_kind_i, reg_count_i, ptpl_i);
				end else begin
					next_wr_data = rec_data_i;
				end
				next_wr_addr = addr;
				next_wr_valid = 1'b1;
				next_state = S_PUT;
			end
			S_PUT: begin
				if (wr_ready_i) begin
					next_wr_valid = 1'b0;
					next_idx = step_idx;
					next_addr = step_addr;
					if (step_idx >= total) begin
						next_state = S_CPL;
					end else if (!use_sgl && step_addr[PB-1:0] == '0) begin
						// second entry is buffer or list pointer
						if (!need_list && !crossed) begin
							next_addr = ptr2;
							next_crossed = 1'b1;
							next_state = S_SEL;
						end else begin
							next_rd_req = 1'b1;
							next_rd_addr = list_ptr;
							next_list_ptr = list_ptr + resv_cmd_pkg::LIST_STEP;
							next_state = S_LIST_RD;
						end
					end else begin
						next_state = S_SEL;
					end
				end
			end
			S_LIST_RD: begin
				if (rd_ack_i) begin
					next_rd_req = 1'b0;
					next_addr = rd_data_i;
					next_state = S_SEL;
				end
			end
			S_CPL: begin
				if (!cpl_valid_o) begin
					next_cpl_valid = 1'b1;
				end else if (cpl_ready_i) begin
					next_cpl_valid = 1'b0;
					next_cmd_ready = 1'b1;
					next_state = S_IDLE;
				end
			end
			default: begin
				next_state = S_IDLE;
				next_cmd_ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= S_IDLE;
			cmd_ready_o <= 1'b1;
			rd_req_o <= 1'b0;
			rd_addr_o <= '0;
			wr_valid_o <= 1'b0;
			wr_addr_o <= '0;
			wr_data_o <= '0;
			rec_index_o <= '0;
			cpl_valid_o <= 1'b0;
			cpl_sqid_o <= '0;
			cpl_cid_o <= '0;
			cpl_status_o <= '0;
			release_o <= 1'b0;
			clear_o <= 1'b0;
			generation_counter_o <= '0;
			addr <= '0;
			ptr2 <= '0;
			list_ptr <= '0;
			idx <= '0;
			total <= '0;
			kind_req <= '0;
			act <= '0;
			bypass <= 1'b0;
			key_match <= 1'b0;
			use_sgl <= 1'b0;
			need_list <= 1'b0;
			crossed <= 1'b0;
		end else begin
			state <= next_state;
			cmd_ready_o <= next_cmd_ready;
			rd_req_o <= next_rd_req;
			rd_addr_o <= next_rd_addr;
			wr_valid_o <= next_wr_valid;
			wr_addr_o <= next_wr_addr;
			wr_data_o <= next_wr_data;
			rec_index_o <= next_rec_index;
			cpl_valid_o <= next_cpl_valid;
			cpl_sqid_o <= next_cpl_sqid;
			cpl_cid_o <= next_cpl_cid;
			cpl_status_o <= next_cpl_status;
			release_o <= next_release;
			clear_o <= next_clear;
			generation_counter_o <= next_gen;
			addr <= next_addr;
			ptr2 <= next_ptr2;
			list_ptr <= next_list_ptr;
			idx <= next_idx;
			total <= next_total;
			kind_req <= next_kind_req;
			act <= next_act;
			bypass <= next_bypass;
			key_match <= next_key_match;
			use_sgl <= next_use_sgl;
			need_list <= next_need_list;
			crossed <= next_crossed;
		end
	end
endmodule

`default_nettype wire

// >>> resv_cmd_pkg.sv
// resv_cmd_pkg: constants for the reservation release / report interpreter.
// assumes: included first in compile order; no other package needed.
package resv_cmd_pkg;
	// ==========================================================
	// command dword 0 fields
	localparam int CDW0_DPTR_SEL_BIT = 15;
	localparam int CDW0_OPC_HI = 7;
	localparam int CDW0_OPC_LO = 0;
	localparam int CDW0_CID_HI = 31;
	localparam int CDW0_CID_LO = 16;
	// ==========================================================
	// command dword 10 fields (release)
	localparam int KIND_HI = 15;
	localparam int KIND_LO = 8;
	localparam int BYPASS_BIT = 3;
	localparam int ACT_HI = 2;
	localparam int ACT_LO = 0;
	localparam logic [2:0] ACT_RELEASE = 3'h0;
	localparam logic [2:0] ACT_CLEAR = 3'h1;
	// ==========================================================
	// data pointer fields
	localparam int PTR1_HI = 63;
	localparam int PTR1_LO = 0;
	localparam int PTR2_HI = 127;
	localparam int PTR2_LO = 64;
	localparam int SGL_LEN_HI = 95;
	localparam int SGL_LEN_LO = 64;
	// ==========================================================
	// status structure layout, in dwords
	localparam int HDR_DW = 6;
	localparam int REC_DW = 6;
	localparam int HDR_GEN = 0;
	localparam int HDR_KIND = 1;
	localparam int HDR_PTPL = 2;
	localparam int PTPL_BIT = 8;
	localparam logic [63:0] DW_BYTES = 64'h4;
	localparam logic [63:0] LIST_STEP = 64'h8;
	// ==========================================================
	// completion status codes
	localparam logic [7:0] ST_SUCCESS = 8'h00;
	localparam logic [7:0] ST_BAD_OPCODE = 8'h01;
	localparam logic [7:0] ST_BAD_FIELD = 8'h02;
	localparam logic [7:0] ST_SGL_LENGTH = 8'h0F;
	localparam logic [7:0] ST_CONFLICT = 8'h83;
endpackage

// >>> resv_props.sv
// resv_props: port-level timing checks of the interpreter
// assumes: bound into reservation_release_report, one clock domain
`timescale 1ns/100ps
`default_nettype none
module resv_props #(
	parameter logic [7:0] OPC_RELEASE = 8'h01
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire logic [31:0] cmd_cdw0_i,
	input wire logic [31:0] cmd_cdw10_i,
	input wire logic rd_req_o,
	input wire logic [63:0] rd_addr_o,
	input wire logic rd_ack_i,
	input wire logic wr_valid_o,
	input wire logic [63:0] wr_addr_o,
	input wire logic [31:0] wr_data_o,
	input wire logic wr_ready_i,
	input wire logic cpl_valid_o,
	input wire logic [7:0] cpl_status_o,
	input wire logic cpl_ready_i,
	input wire logic clear_o,
	input wire logic gen_bump_i,
	input wire logic [31:0] generation_counter_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================
	// command steps
	sequence take_s;
		cmd_valid_i && cmd_ready_o;
	endsequence
	sequence rel_s;
		take_s ##0 cmd_cdw0_i[7:0] == OPC_RELEASE;
	endsequence
	sequence done_s;
		cpl_valid_o && cpl_ready_i;
	endsequence
	take_busy_a: assert property (take_s |=> !cmd_ready_o)
		else $error("ready stayed high after take");
	bypass_lat_a: assert property (rel_s ##0 cmd_cdw10_i[3:1] == 3'h4 |=>
		!cpl_valid_o [*2] ##1 cpl_valid_o) else $error("bypass latency");
	rsv_act_a: assert property (rel_s ##0 cmd_cdw10_i[2:1] != 2'h0 |=>
		!cpl_valid_o ##1 (cpl_valid_o && cpl_status_o == 8'h02))
		else $error("reserved action not refused");
	cpl_end_a: assert property (done_s |=> !cpl_valid_o && cmd_ready_o)
		else $error("completion did not end");
	cpl_hold_a: assert property (cpl_valid_o && !cpl_ready_i |=>
		cpl_valid_o && $stable(cpl_status_o)) else $error("completion dropped");
	rd_hold_a: assert property (rd_req_o && !rd_ack_i |=>
		rd_req_o && $stable(rd_addr_o)) else $error("read not held");
	rd_drop_a: assert property (rd_req_o && rd_ack_i |=> !rd_req_o)
		else $error("read not dropped");
	wr_hold_a: assert property (wr_valid_o && !wr_ready_i |=>
		wr_valid_o && $stable({wr_addr_o, wr_data_o})) else $error("write moved");
	gen_step_a: assert property ($changed(generation_counter_o) &&
		!$past(gen_bump_i) && !$past(gen_bump_i, 2) |->
		generation_counter_o == $past(generation_counter_o) + 32'h1)
		else $error("generation step wrong");
	clear_gen_a: assert property (clear_o |-> ##[0:1] $changed(generation_counter_o))
		else $error("clear without generation step");
endmodule
bind reservation_release_report resv_props #(.OPC_RELEASE(OPC_RELEASE)) props (
	.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
	.cmd_ready_o(cmd_ready_o), .cmd_cdw0_i(cmd_cdw0_i), .cmd_cdw10_i(cmd_cdw10_i),
	.rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_ack_i(rd_ack_i),
	.wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
	.wr_ready_i(wr_ready_i), .cpl_valid_o(cpl_valid_o),
	.cpl_status_o(cpl_status_o), .cpl_ready_i(cpl_ready_i), .clear_o(clear_o),
	.gen_bump_i(gen_bump_i), .generation_counter_o(generation_counter_o));
`default_nettype wire

// >>> tb.sv
// tb: self-checking bench for reservation_release_report
// assumes: host_model answers reads, writes and completions
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk = 0, rst = 1, cmd_valid = 0, ptpl = 0, gen_bump = 0, slow = 0;
	logic [31:0] cdw0 = '0, cdw10 = '0;
	logic [127:0] dptr = '0;
	logic [15:0] sqid = '0, reg_count = '0;
	logic [7:0] held_kind = '0;
	logic [63:0] holder_key = 64'h1122334455667788, key = 64'h1122334455667788;
	wire cmd_ready, rd_req, rd_ack, wr_valid, wr_ready, cpl_valid, cpl_ready;
	wire rel_p, clr_p;
	wire [63:0] rd_addr, rd_data, wr_addr;
	wire [31:0] wr_data, rec_data, gen;
	wire [18:0] rec_index;
	wire [15:0] cpl_sqid, cpl_cid;
	wire [7:0] cpl_status;
	int error_cnt = 0, check_count = 0, rel_n, clr_n;
	// expected generation, kept from the rules, not read from the design
	logic [31:0] gen_ref = '0;
	reservation_release_report uut (.clk_i(clk), .rst_i(rst),
		.cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_cdw0_i(cdw0),
		.cmd_cdw10_i(cdw10), .cmd_dptr_i(dptr), .cmd_sqid_i(sqid),
		.held_kind_i(held_kind), .holder_key_i(holder_key),
		.reg_count_i(reg_count), .ptpl_i(ptpl), .gen_bump_i(gen_bump),
		.rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_ack_i(rd_ack),
		.rd_data_i(rd_data), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr),
		.wr_data_o(wr_data), .wr_ready_i(wr_ready), .rec_index_o(rec_index),
		.rec_data_i(rec_data), .cpl_valid_o(cpl_valid), .cpl_sqid_o(cpl_sqid),
		.cpl_cid_o(cpl_cid), .cpl_status_o(cpl_status),
		.cpl_ready_i(cpl_ready), .release_o(rel_p), .clear_o(clr_p),
		.generation_counter_o(gen));
	host_model host (.clk_i(clk), .rst_i(rst), .slow_i(slow), .key_i(key),
		.rd_req_i(rd_req), .rd_ack_o(rd_ack), .rd_data_o(rd_data),
		.wr_valid_i(wr_valid), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
		.wr_ready_o(wr_ready), .rec_index_i(rec_index), .rec_data_o(rec_data),
		.cpl_ready_o(cpl_ready));
	always #50 clk = ~clk;
	always @(posedge clk) begin
		if (rel_p === 1'b1) rel_n++;
		if (clr_p === 1'b1) clr_n++;
	end
	// ==========================================
	// shared steps
	task automatic chk(input logic [63:0] got, exp, input string what);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// key fetch must read the release data at the first pointer entry
	always @(posedge clk) begin
		if (rd_req === 1'b1 && rd_ack === 1'b1) begin
			chk(rd_addr, 64'h8000, "key address");
		end
	end
	function automatic logic [31:0] op(input logic [7:0] c, input logic sgl);
		return {8'h5A, c, sgl, 7'h0, c};
	endfunction
	task automatic run(input logic [31:0] c0, c10, input logic [127:0] p,
			input logic [7:0] st);
		int n;
		@(posedge clk);
		rel_n = 0;
		clr_n = 0;
		host.wr_cnt = 0;
		cmd_valid <= 1'b1;
		cdw0 <= c0;
		cdw10 <= c10;
		dptr <= p;
		sqid <= sqid + 16'h3;
		n = 0;
		do begin @(posedge clk); n++; end while (cmd_ready !== 1'b1 && n < 50);
		cmd_valid <= 1'b0;
		n = 0;
		do begin @(posedge clk); n++; end
			while (!(cpl_valid === 1'b1 && cpl_ready === 1'b1) && n < 3000);
		chk(cpl_status, st, "status");
		chk({cpl_cid, cpl_sqid}, {c0[31:16], sqid}, "ids");
		@(posedge clk);
	endtask
	task automatic vrf(input logic [63:0] p1, p2, input int n);
		logic [63:0] a, pg;
		logic [31:0] e;
		chk(host.wr_cnt, n, "write count");
		pg = (p1 | 64'hFFF) + 64'h1;
		for (int i = 0; i < n; i++) begin
			a = p1 + 64'(4 * i);
			if (a >= pg) a = p2 + a - pg;
			case (i)
				0: e = gen_ref;
				1: e = {8'h0, reg_count, held_kind};
				2: e = {23'h0, ptpl, 8'h0};
				3, 4, 5: e = 32'h0;
				default: e = {16'hC0DE, 16'(i - 6)};
			endcase
			chk(host.mem.exists(a) ? host.mem[a] : 32'hX, e, "data");
		end
	endtask
	// ==========================================
	// scenarios
	task automatic t_release();
		held_kind <= 8'h02;
		slow <= 1'b1;
		run(op(8'h01, 0), 32'hBEEF0200, 128'h8000, 8'h00);
		chk(rel_n, 1, "release pulse");
		key <= ~key;
		run(op(8'h01, 0), 32'h0200, 128'h8000, 8'h83);
		chk(rel_n, 0, "no release");
		run(op(8'h01, 0), 32'h0208, 128'h8000, 8'h00);
		run(op(8'h01, 0), 32'h0308, 128'h8000, 8'h83);
		key <= holder_key;
		slow <= 1'b0;
	endtask
	task automatic t_clear();
		logic [31:0] g;
		g = gen_ref;
		run(op(8'h01, 1), 32'h0501, 128'h8000, 8'h00);
		chk({clr_n, gen}, {32'h1, g + 32'h1}, "clear");
		gen_bump <= 1'b1;
		@(posedge clk);
		gen_bump <= 1'b0;
		repeat (2) @(posedge clk);
		chk(gen, g + 32'h2, "bump");
		gen_ref = g + 32'h2;
		for (int a = 2; a < 8; a++) begin
			run(op(8'h01, 0), 32'h0208 | a, 128'h8000, 8'h02);
			chk(rel_n + clr_n, 0, "no action");
		end
		run(op(8'h7E, 0), 32'h0, 128'h8000, 8'h01);
	endtask
	task automatic t_report();
		reg_count <= 16'h1;
		ptpl <= 1'b1;
		slow <= 1'b1;
		run(op(8'h02, 0), 32'h3, {64'h5000, 64'h1FF8}, 8'h00);
		vrf(64'h1FF8, 64'h5000, 4);
		slow <= 1'b0;
		run(op(8'h02, 0), 32'h64, {64'h0, 64'h3000}, 8'h00);
		vrf(64'h3000, 64'h0, 12);
		run(op(8'h02, 1), 32'h4, {32'h0, 32'h10, 64'h7000}, 8'h0F);
		chk(host.wr_cnt, 0, "sgl short");
		run(op(8'h02, 1), 32'h3, {32'h0, 32'h10, 64'h7000}, 8'h00);
		vrf(64'h7000, 64'h0, 4);
	endtask
	task automatic report_and_stop();
		if (error_cnt == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_release();
		t_clear();
		t_report();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
endmodule
`default_nettype wire
